// *** design/idm_defs.svh ***
/*
 * Constants of the internal data memory block: addresses, reset values,
 * field positions and sizes. Assumes it is included by bare name.
 */
`ifndef IDM_DEFS_SVH
`define IDM_DEFS_SVH

`define IDM_RAM_BYTES     256
`define IDM_LOWER_TOP     8'h7F
`define IDM_UPPER_BASE    8'h80
`define IDM_SP_ADDR       8'h81
`define IDM_SP_RESET      8'h07
`define IDM_BIT_BYTE_BASE 8'h20
`define IDM_BIT_BYTE_TOP  8'h2F
`define IDM_BANK_LO_BIT   3
`define IDM_BANK_HI_BIT   4
`define IDM_REC_DEPTH     32
`define IDM_CALL_REC_BITS 2'h3
`define IDM_PUSH_REC_BIT  1'h0

`endif

// *** design/idm_pkg.sv ***
/*
 * Types of the internal data memory block: access commands from the core
 * and stack record commands. Assumes nothing of its surroundings.
 */
package idm_pkg;

    typedef enum logic [3:0] {
        OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
        OP_REG_RD, OP_REG_WR, OP_BIT_RD, OP_BIT_WR,
        OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_SP_INC, OP_SP_DEC
    } idm_op_t;

    typedef enum logic [2:0] {
        REC_NONE, REC_PUSH1, REC_PUSH2, REC_POP1, REC_POP2
    } idm_rec_t;

endpackage

// *** design/idm_stack_record.sv ***
/*
 * Stack record shift register with overflow and underflow detection.
 * Assumes one record command per sys_clk cycle from the memory block.
 */
`timescale 1ns/100ps
`include "idm_defs.svh"

module idm_stack_record #(
    parameter int DEPTH = `IDM_REC_DEPTH
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire idm_pkg::idm_rec_t recOp,
    input  wire logic              debugClear,
    output logic                   overflow,
    output logic                   underflow
);
    import idm_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    logic [DEPTH-1:0] bits_reg;
    logic [CW-1:0]    count_reg;
    logic             ovf_reg;
    logic             unf_reg;
    logic             ovfHit;
    logic             unfHit;

    assign ovfHit = (recOp == REC_PUSH1 && count_reg == CW'(DEPTH))
                 || (recOp == REC_PUSH2 && count_reg >= CW'(DEPTH - 1));
    assign unfHit = (recOp == REC_POP1 && count_reg == '0)
                 || (recOp == REC_POP2 && count_reg < CW'(2));

    // Oldest bits fall off the top on overflow; the count saturates
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bits_reg  <= '0;
            count_reg <= '0;
        end else begin
            case (recOp)
                REC_PUSH1: begin
                    bits_reg  <= {bits_reg[DEPTH-2:0], `IDM_PUSH_REC_BIT};
                    count_reg <= ovfHit ? CW'(DEPTH) : count_reg + CW'(1);
                end
                REC_PUSH2: begin
                    bits_reg  <= {bits_reg[DEPTH-3:0], `IDM_CALL_REC_BITS};
                    count_reg <= ovfHit ? CW'(DEPTH) : count_reg + CW'(2);
                end
                REC_POP1: begin
                    bits_reg  <= {1'b0, bits_reg[DEPTH-1:1]};
                    count_reg <= unfHit ? '0 : count_reg - CW'(1);
                end
                REC_POP2: begin
                    bits_reg  <= {2'b00, bits_reg[DEPTH-1:2]};
                    count_reg <= unfHit ? '0 : count_reg - CW'(2);
                end
                default: ;
            endcase
        end
    end

    // Sticky for the debug logic; a new event beats the clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end else begin
            ovf_reg <= ovfHit | (ovf_reg & ~debugClear);
            unf_reg <= unfHit | (unf_reg & ~debugClear);
        end
    end

    assign overflow  = ovf_reg;
    assign underflow = unf_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_rec_underflow: assert property (
        (recOp == REC_POP1 && count_reg == '0) || (recOp == REC_POP2 && count_reg < CW'(2))
        |=> underflow)
        else $error("pop of empty record not flagged");
    a_rec_overflow: assert property (
        recOp == REC_PUSH2 && count_reg == CW'(DEPTH) |=> overflow && count_reg == CW'(DEPTH))
        else $error("record overflow not flagged");
endmodule

// *** design/idm_data_memory.sv ***
/*
 * Internal data memory of the core: 256 byte RAM, register banks, bit
 * area, stack pointer and stack record, and routing of direct accesses
 * above 0x7F, except the stack pointer at 0x81, to the special register
 * space outside. Assumes the core issues at most one access per sys_clk
 * cycle and keeps off reserved special register addresses.
 */
`timescale 1ns/100ps
`include "idm_defs.svh"

// Functional notes
// - 256 bytes of RAM, addresses 0x00-0xFF
// - lower 128 bytes same by direct/indirect
// - indirect above 0x7F reaches upper RAM
// - direct from 0x80 goes to special registers
// - bottom 32 bytes are four register banks
// - status bits 3/4 select active bank
// - indirect address from bank register 0/1
// - bytes 0x20-0x2F hold 128 addressable bits
// - bit or byte chosen by operand type
// - push writes pointer+1, then advances pointer
// - reset loads pointer with 0x07
// - stack may use all 256 RAM bytes
// - record shifts in one/two bits per push/call
// - record shifts out one/two per pop/return
// - record overflow/underflow flagged to debug
// - special registers ending 0/8 are bit-addressable
// - other special registers byte access only
module idm_data_memory #(
    parameter int RAM_BYTES = `IDM_RAM_BYTES,
    parameter int REC_DEPTH = `IDM_REC_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             opValid,
    input  wire idm_pkg::idm_op_t opCode,
    input  wire logic [7:0]       opAddr,
    input  wire logic [15:0]      opWdata,
    input  wire logic [7:0]       processorStatusByte,
    input  wire logic             debugClear,
    input  wire logic [7:0]       sfrRdData,
    output logic                  rdValid,
    output logic [15:0]           rdData,
    output logic [7:0]            stackTopIndex,
    output logic                  sfrRdEn,
    output logic                  sfrWrEn,
    output logic                  sfrBitWr,
    output logic [7:0]            sfrAddr,
    output logic [7:0]            sfrWdata,
    output logic [2:0]            sfrBitPos,
    output logic                  recOverflow,
    output logic                  recUnderflow
);
    import idm_pkg::*;

    // Storage
    logic [7:0]  ram [RAM_BYTES];
    logic [7:0]  stack_top_index_reg;
    logic [7:0]  stackTopIndex_next;

    // Answer and special register port flops
    logic        rdValid_reg;
    logic [15:0] rdData_reg;
    logic        sfrRdEn_reg;
    logic        sfrWrEn_reg;
    logic        sfrBitWr_reg;
    logic [7:0]  sfrAddr_reg;
    logic [7:0]  sfrWdata_reg;
    logic [2:0]  sfrBitPos_reg;

    // Special register read in flight
    logic        sfrPend_reg;
    logic        sfrPendBit_reg;

    // Decode
    logic        act;
    logic [1:0]  bank;
    logic [7:0]  idxAddr;
    logic [7:0]  bitByte;
    logic        bitInRam;
    logic        dirIsRam;
    logic        dirIsSp;
    logic [7:0]  regByte;
    logic [7:0]  spPlus1;
    logic [7:0]  spPlus2;
    logic [7:0]  spMinus1;
    idm_rec_t    recOp;

    // Byte that holds working register n of a bank
    function automatic logic [7:0] regLoc(input logic [1:0] bk,
                                          input logic [2:0] n);
        regLoc = {3'h0, bk, n};
    endfunction

    // Byte that holds a bit address; the upper half only ever lands on
    // addresses ending in 0 or 8, so other special registers stay
    // unreachable by bit operations
    function automatic logic [7:0] bitLoc(input logic [7:0] ba);
        if (ba[7]) begin
            bitLoc = {ba[7:3], 3'h0};
        end else begin
            bitLoc = `IDM_BIT_BYTE_BASE + {4'h0, ba[6:3]};
        end
    endfunction

    assign act      = opValid;
    assign bank     = {processorStatusByte[`IDM_BANK_HI_BIT],
                       processorStatusByte[`IDM_BANK_LO_BIT]};
    // Index register 0 or 1 of the active bank, picked by opAddr[0]
    assign idxAddr  = ram[regLoc(bank, {2'h0, opAddr[0]})];
    assign regByte  = regLoc(bank, opAddr[2:0]);
    assign bitByte  = bitLoc(opAddr);
    assign bitInRam = ~opAddr[7];
    assign dirIsRam = opAddr <= `IDM_LOWER_TOP;
    assign dirIsSp  = opAddr == `IDM_SP_ADDR;
    assign spPlus1  = stack_top_index_reg + 8'h01;
    assign spPlus2  = stack_top_index_reg + 8'h02;
    assign spMinus1 = stack_top_index_reg - 8'h01;

    // Stack pointer next value; wraps modulo 256 by its width
    always_comb begin
        stackTopIndex_next = stack_top_index_reg;
        if (act) begin
            case (opCode)
                OP_PUSH:   stackTopIndex_next = spPlus1;
                OP_SP_INC: stackTopIndex_next = spPlus1;
                OP_CALL:   stackTopIndex_next = spPlus2;
                OP_POP:    stackTopIndex_next = spMinus1;
                OP_SP_DEC: stackTopIndex_next = spMinus1;
                OP_RET:    stackTopIndex_next = stack_top_index_reg - 8'h02;
                OP_DIR_WR: begin
                    if (dirIsSp) begin
                        stackTopIndex_next = opWdata[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stack_top_index_reg <= `IDM_SP_RESET;
        end else begin
            stack_top_index_reg <= stackTopIndex_next;
        end
    end

    // RAM writes. Stack uses the full array, like indirect access, so a
    // pointer above 0x7F never touches the special register space.
    always_ff @(posedge sys_clk) begin
        if (!srst && act) begin
            case (opCode)
                OP_DIR_WR: begin
                    if (dirIsRam) begin
                        ram[opAddr] <= opWdata[7:0];
                    end
                end
                OP_IND_WR: ram[idxAddr] <= opWdata[7:0];
                OP_REG_WR: ram[regByte] <= opWdata[7:0];
                OP_BIT_WR: begin
                    if (bitInRam) begin
                        ram[bitByte][opAddr[2:0]] <= opWdata[0];
                    end
                end
                OP_PUSH: ram[spPlus1] <= opWdata[7:0];
                OP_CALL: begin
                    ram[spPlus1] <= opWdata[7:0];
                    ram[spPlus2] <= opWdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Answers from RAM come one edge after the request; answers from
    // the special register space one edge later, after its read strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdValid_reg <= 1'b0;
            rdData_reg  <= 16'h0000;
        end else if (sfrPend_reg) begin
            rdValid_reg <= 1'b1;
            rdData_reg  <= sfrPendBit_reg ?
                           {15'h0000, sfrRdData[sfrBitPos_reg]} :
                           {8'h00, sfrRdData};
        end else begin
            rdValid_reg <= 1'b0;
            if (act) begin
                case (opCode)
                    OP_DIR_RD: begin
                        if (dirIsRam) begin
                            rdValid_reg <= 1'b1;
                            rdData_reg  <= {8'h00, ram[opAddr]};
                        end else if (dirIsSp) begin
                            rdValid_reg <= 1'b1;
                            rdData_reg  <= {8'h00, stack_top_index_reg};
                        end
                    end
                    OP_IND_RD: begin
                        rdValid_reg <= 1'b1;
                        rdData_reg  <= {8'h00, ram[idxAddr]};
                    end
                    OP_REG_RD: begin
                        rdValid_reg <= 1'b1;
                        rdData_reg  <= {8'h00, ram[regByte]};
                    end
                    OP_BIT_RD: begin
                        if (bitInRam) begin
                            rdValid_reg <= 1'b1;
                            rdData_reg  <= {15'h0000, ram[bitByte][opAddr[2:0]]};
                        end
                    end
                    OP_POP: begin
                        rdValid_reg <= 1'b1;
                        rdData_reg  <= {8'h00, ram[stack_top_index_reg]};
                    end
                    OP_RET: begin
                        rdValid_reg <= 1'b1;
                        rdData_reg  <= {ram[stack_top_index_reg], ram[spMinus1]};
                    end
                    default: ;
                endcase
            end
        end
    end

    // Special register strobes, one cycle each
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sfrRdEn_reg    <= 1'b0;
            sfrWrEn_reg    <= 1'b0;
            sfrBitWr_reg   <= 1'b0;
            sfrAddr_reg    <= 8'h00;
            sfrWdata_reg   <= 8'h00;
            sfrBitPos_reg  <= 3'h0;
            sfrPend_reg    <= 1'b0;
            sfrPendBit_reg <= 1'b0;
        end else begin
            sfrRdEn_reg    <= 1'b0;
            sfrWrEn_reg    <= 1'b0;
            sfrBitWr_reg   <= 1'b0;
            sfrPend_reg    <= 1'b0;
            sfrPendBit_reg <= 1'b0;
            if (act) begin
                case (opCode)
                    OP_DIR_RD: begin
                        if (!dirIsRam && !dirIsSp) begin
                            sfrRdEn_reg <= 1'b1;
                            sfrAddr_reg <= opAddr;
                            sfrPend_reg <= 1'b1;
                        end
                    end
                    OP_DIR_WR: begin
                        if (!dirIsRam && !dirIsSp) begin
                            sfrWrEn_reg  <= 1'b1;
                            sfrAddr_reg  <= opAddr;
                            sfrWdata_reg <= opWdata[7:0];
                        end
                    end
                    OP_BIT_RD: begin
                        if (!bitInRam) begin
                            sfrRdEn_reg    <= 1'b1;
                            sfrAddr_reg    <= bitByte;
                            sfrBitPos_reg  <= opAddr[2:0];
                            sfrPend_reg    <= 1'b1;
                            sfrPendBit_reg <= 1'b1;
                        end
                    end
                    OP_BIT_WR: begin
                        if (!bitInRam) begin
                            sfrBitWr_reg  <= 1'b1;
                            sfrAddr_reg   <= bitByte;
                            sfrBitPos_reg <= opAddr[2:0];
                            sfrWdata_reg  <= {7'h00, opWdata[0]};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Record commands follow the stack operations
    always_comb begin
        recOp = REC_NONE;
        if (act) begin
            case (opCode)
                OP_PUSH, OP_SP_INC: recOp = REC_PUSH1;
                OP_CALL:            recOp = REC_PUSH2;
                OP_POP, OP_SP_DEC:  recOp = REC_POP1;
                OP_RET:             recOp = REC_POP2;
                default:            recOp = REC_NONE;
            endcase
        end
    end

    idm_stack_record #(
        .DEPTH (REC_DEPTH)
    ) u_record (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .recOp      (recOp),
        .debugClear (debugClear),
        .overflow   (recOverflow),
        .underflow  (recUnderflow)
    );

    assign rdValid       = rdValid_reg;
    assign rdData        = rdData_reg;
    assign stackTopIndex = stack_top_index_reg;
    assign sfrRdEn       = sfrRdEn_reg;
    assign sfrWrEn       = sfrWrEn_reg;
    assign sfrBitWr      = sfrBitWr_reg;
    assign sfrAddr       = sfrAddr_reg;
    assign sfrWdata      = sfrWdata_reg;
    assign sfrBitPos     = sfrBitPos_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_sp_reset: assert property (disable iff (1'b0)
        srst |=> stackTopIndex == `IDM_SP_RESET)
        else $error("stack pointer not 0x07 after reset");

    a_push_advance: assert property (
        act && opCode == OP_PUSH |=> stackTopIndex == $past(stackTopIndex) + 8'h01
            && ram[stackTopIndex] == $past(opWdata[7:0]))
        else $error("push did not land at pointer plus one");

    a_pop_data: assert property (
        act && opCode == OP_POP |=> rdValid && stackTopIndex == $past(spMinus1))
        else $error("pop did not answer and decrement");

    a_dir_sfr_route: assert property (
        act && opCode == OP_DIR_RD && opAddr >= `IDM_UPPER_BASE && !dirIsSp
        |=> sfrRdEn && !rdValid ##1 rdValid)
        else $error("direct upper read not routed to special registers");

    a_ind_upper_ram: assert property (
        act && (opCode == OP_IND_RD || opCode == OP_IND_WR)
        |=> !sfrRdEn && !sfrWrEn && !sfrBitWr)
        else $error("indirect access reached special registers");

    a_stack_no_sfr: assert property (
        act && opCode inside {OP_PUSH, OP_POP, OP_CALL, OP_RET}
        |=> !sfrRdEn && !sfrWrEn)
        else $error("stack access reached special registers");

    a_bit_aligned: assert property (
        sfrBitWr || (sfrRdEn && $past(opCode == OP_BIT_RD && act))
        |-> sfrAddr[2:0] == 3'h0)
        else $error("bit access to a byte-only special register");

    a_bit_ram_range: assert property (
        act && opCode == OP_BIT_WR && bitInRam
        |-> bitByte >= `IDM_BIT_BYTE_BASE && bitByte <= `IDM_BIT_BYTE_TOP)
        else $error("bit address outside the bit area");

    a_reg_bank: assert property (
        act && opCode == OP_REG_WR
        |-> regByte == {3'h0, processorStatusByte[4:3], opAddr[2:0]})
        else $error("working register mapped to wrong bank");

    c_call_ret: cover property (
        act && opCode == OP_CALL ##[1:20] act && opCode == OP_RET);
    c_sfr_bit_rd: cover property (act && opCode == OP_BIT_RD && !bitInRam);
    c_rec_over: cover property (recOverflow);
endmodule

// *** test/idm_sfr_model.sv ***
/*
 * Model of the special register space behind idm_data_memory: byte store
 * with single-bit writes. Assumes one strobe per sys_clk cycle.
 */
`timescale 1ns/100ps

module idm_sfr_model (
    input  wire logic       sys_clk,
    input  wire logic       sfrRdEn,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrBitWr,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWdata,
    input  wire logic [2:0] sfrBitPos,
    output logic [7:0]      sfrRdData
);
    logic [7:0] regs [128];
    logic [7:0] noise = 8'hA5;

    always @(posedge sys_clk) begin
        noise <= noise + 8'h3B;
        if (sfrWrEn) begin
            regs[sfrAddr[6:0]] <= sfrWdata;
        end
        // Bit path only reaches bytes ending in 0 or 8
        if (sfrBitWr && sfrAddr[2:0] == 3'h0) begin
            regs[sfrAddr[6:0]][sfrBitPos] <= sfrWdata[0];
        end
    end

    // Unselected read bus keeps moving so stale data cannot pass
    assign sfrRdData = sfrRdEn ? regs[sfrAddr[6:0]] : noise;
endmodule

// *** test/internal_data_memory_map_tb_top.sv ***
/*
 * Self-checking bench for idm_data_memory: plays the core, models RAM,
 * pointer and record with integers. Assumes idm_sfr_model on the far side.
 */
`timescale 1ns/100ps

module internal_data_memory_map_tb_top;
    import idm_pkg::*;
    logic        sys_clk, srst, opValid, debugClear, rdValid, recOverflow, recUnderflow;
    logic        sfrRdEn, sfrWrEn, sfrBitWr;
    idm_op_t     opCode;
    logic [7:0]  opAddr, processorStatusByte, sfrRdData, stackTopIndex, sfrAddr, sfrWdata;
    logic [15:0] opWdata, rdData;
    logic [2:0]  sfrBitPos;
    int          err_count, comparisons, cycles, seed, sp, rec, ovf, unf, i, a;
    int          mem [512];
    logic [31:0] expQ [$];

    idm_data_memory u_dut (
        .sys_clk, .srst, .opValid, .opCode, .opAddr, .opWdata, .processorStatusByte,
        .debugClear, .sfrRdData, .rdValid, .rdData, .stackTopIndex, .sfrRdEn, .sfrWrEn,
        .sfrBitWr, .sfrAddr, .sfrWdata, .sfrBitPos, .recOverflow, .recUnderflow
    );
    idm_sfr_model u_sfr (
        .sys_clk, .sfrRdEn, .sfrWrEn, .sfrBitWr, .sfrAddr, .sfrWdata, .sfrBitPos, .sfrRdData
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    // Unexpected answers fail too: empty queue compares 1 against 0
    always @(posedge sys_clk) begin
        #2;
        if (rdValid === 1'b1 && expQ.size() == 0) begin
            check(16'h0001, 16'h0000);
        end else if (rdValid === 1'b1) begin
            check(rdData & expQ[0][31:16], expQ[0][15:0]);
            void'(expQ.pop_front());
        end
    end

    function automatic int rg(input int n);
        return processorStatusByte[4:3] * 8 + n;
    endfunction

    task automatic rc(input int n);
        rec += n;
        ovf |= int'(rec > 32);
        unf |= int'(rec < 0);
        rec = (rec > 32) ? 32 : (rec < 0) ? 0 : rec;
    endtask

    task automatic idle(input int n);
        opValid = 1'b0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic flags;
        check(16'({recOverflow, recUnderflow}), 16'(ovf * 2 + unf));
    endtask

    task automatic do_reset;
        srst = 1'b1;
        opValid = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        sp = 7;
        rec = 0;
        ovf = 0;
        unf = 0;
        check(16'(stackTopIndex), 16'h0007);
        check(16'({rdValid, recOverflow, recUnderflow}), 16'h0000);
    endtask

    // Model first, then one request; entered at posedge + 1 only
    task automatic op(input idm_op_t c, input int ad, input int wd);
        int t;
        int sh;
        int mm;
        sh = (c inside {OP_BIT_RD, OP_BIT_WR}) ? ad % 8 : 0;
        mm = (c inside {OP_BIT_RD, OP_BIT_WR}) ? 1 : 255;
        case (c)
            OP_DIR_RD, OP_DIR_WR: t = (ad < 128) ? ad : (ad == 129) ? -1 : 256 + ad;
            OP_IND_RD, OP_IND_WR: t = mem[rg(ad % 2)];
            OP_REG_RD, OP_REG_WR: t = rg(ad % 8);
            OP_BIT_RD, OP_BIT_WR: t = (ad < 128) ? 32 + ad / 8 : 256 + ad - sh;
            default: t = 0;
        endcase
        if (c inside {OP_DIR_RD, OP_IND_RD, OP_REG_RD, OP_BIT_RD}) begin
            expQ.push_back({16'(mm), 16'((((t < 0) ? sp : mem[t]) >> sh) & mm)});
        end
        if (c inside {OP_DIR_WR, OP_IND_WR, OP_REG_WR, OP_BIT_WR}) begin
            mem[(t < 0) ? 0 : t] = (t < 0) ? mem[0] : (mem[t] & ~(mm << sh)) | ((wd & mm) << sh);
            sp = (t < 0) ? wd & 255 : sp;
        end
        case (c)
            OP_PUSH, OP_SP_INC: begin
                sp = (sp + 1) & 255;
                mem[sp] = (c == OP_PUSH) ? wd & 255 : mem[sp];
                rc(1);
            end
            OP_POP, OP_SP_DEC: begin
                if (c == OP_POP) begin
                    expQ.push_back({16'h00FF, 16'(mem[sp])});
                end
                sp = (sp - 1) & 255;
                rc(-1);
            end
            OP_CALL: begin
                mem[(sp + 1) & 255] = wd & 255;
                mem[(sp + 2) & 255] = (wd >> 8) & 255;
                sp = (sp + 2) & 255;
                rc(2);
            end
            OP_RET: begin
                expQ.push_back({16'hFFFF, 16'(mem[sp] * 256 + mem[(sp - 1) & 255])});
                sp = (sp - 2) & 255;
                rc(-2);
            end
            default: ;
        endcase
        opValid = 1'b1;
        opCode = c;
        opAddr = 8'(ad);
        opWdata = 16'(wd);
        @(posedge sys_clk);
        #1;
        // Special register answers take the next slot: leave it free
        if (t > 255 && c inside {OP_DIR_RD, OP_BIT_RD}) begin
            idle(1);
        end
        check(16'(stackTopIndex), 16'(sp));
    endtask

    initial begin
        seed = 32'hCD3A;
        srst = 1'b1;
        opValid = 1'b0;
        opCode = OP_NONE;
        opAddr = 8'h00;
        opWdata = 16'h0000;
        processorStatusByte = 8'h00;
        debugClear = 1'b0;
        do_reset();
        for (i = 0; i < 128; i++) begin
            op(OP_DIR_WR, i, $random(seed));
        end
        for (i = 0; i < 40; i++) begin
            processorStatusByte = 8'($random(seed));
            op(OP_REG_WR, i, $random(seed));
            op(OP_REG_RD, i + 1, 0);
            op(OP_DIR_RD, $random(seed) & 127, 0);
        end
        // Occupied bit-addressable registers only; reserved ones stay untouched
        for (i = 0; i < 8; i++) begin
            a = 128 + 8 * i;
            processorStatusByte = 8'(i * 8);
            op(OP_REG_WR, i % 2, a);
            op(OP_IND_WR, i % 2, $random(seed));
            op(OP_DIR_WR, a, $random(seed));
            op(OP_IND_RD, i % 2, 0);
            op(OP_DIR_RD, a, 0);
            op(OP_BIT_WR, a + i, $random(seed));
            op(OP_BIT_RD, a + 7 - i, 0);
            op(OP_DIR_RD, a, 0);
        end
        for (i = 0; i < 48; i++) begin
            a = $random(seed) & 127;
            op(OP_BIT_WR, a, $random(seed));
            op(OP_BIT_RD, a, 0);
            op(OP_DIR_RD, 32 + a / 8, 0);
        end
        op(OP_DIR_WR, 8'h93, 8'h5A);
        op(OP_BIT_WR, 8'h93, 1);
        op(OP_DIR_RD, 8'h93, 0);
        op(OP_DIR_RD, 8'h90, 0);
        op(OP_DIR_WR, 8'h81, 8'h7D);
        for (i = 0; i < 10; i++) begin
            op(i < 5 ? OP_PUSH : OP_POP, 0, $random(seed));
            op(i == 4 ? OP_DIR_RD : OP_NONE, 8'h80, 0);
        end
        op(OP_DIR_WR, 8'h81, 8'hFE);
        op(OP_CALL, 0, $random(seed));
        op(OP_DIR_RD, 8'h81, 0);
        op(OP_RET, 0, 0);
        do_reset();
        for (i = 0; i < 24; i++) begin
            op(i < 8 ? OP_CALL : OP_SP_INC, 0, $random(seed));
        end
        idle(2);
        flags();
        op(OP_PUSH, 0, $random(seed));
        op(OP_CALL, 0, $random(seed));
        idle(2);
        flags();
        debugClear = 1'b1;
        idle(1);
        debugClear = 1'b0;
        ovf = 0;
        op(OP_POP, 0, 0);
        for (i = 0; i < 23; i++) begin
            op(i < 16 ? OP_SP_DEC : OP_RET, 0, 0);
        end
        idle(2);
        flags();
        op(OP_RET, 0, 0);
        idle(3);
        flags();
        check(16'(expQ.size()), 16'h0000);
        end_of_test();
    end
endmodule
